// file: core/sdc_check.sv
/*
 * segment descriptor fetch, decode and access checker with AXI4-Lite registers.
 * assumes the load and check requests and the memory port are logic on clk_sys;
 * memory answers each request with a one-cycle mem_ack.
 */
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns

module sdc_check
	import sdc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	// segment load path
	input wire logic load_valid,
	input wire logic [23:0] load_addr,
	output logic load_busy,
	output logic load_done,
	output sdc_fault_e load_fault,
	// access checks against the cached descriptor
	input wire sdc_chk_s chk,
	output sdc_res_s res,
	// descriptor memory port
	output logic mem_req,
	output logic mem_we,
	output logic mem_lock,
	output logic [23:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	// register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ****************************************
	// state
	// ****************************************
	sdc_state_e state;
	logic [1:0] widx;
	logic [23:0] desc_addr;
	sdc_desc_s stage;
	sdc_desc_s desc;
	logic prot_en;
	logic [15:0] fault_count;
	sdc_fault_e last_fault;

	// ****************************************
	// attribute decode of the cached descriptor
	// ****************************************
	logic is_seg;
	logic is_code;
	logic is_sys;
	logic present;
	logic [1:0] descriptor_privilege;
	logic [3:0] sys_type;
	logic is_tss;
	logic is_ldt;
	sdc_class_e cls;

	assign is_seg = desc.access[SDC_BIT_CLASS]; // [RQ1]
	assign is_code = is_seg && desc.access[SDC_BIT_EXEC]; // [RQ2]
	assign is_sys = !desc.access[SDC_BIT_CLASS]; // [RQ16]
	assign present = desc.access[SDC_BIT_PRESENT];
	assign descriptor_privilege = desc.access[SDC_BIT_DPL_HI:SDC_BIT_DPL_LO]; // [RQ5]
	assign sys_type = desc.access[3:0];
	// busy and free task state share every check here
	assign is_tss = is_sys && (sys_type == SDC_TYPE_TSS_FREE || sys_type == SDC_TYPE_TSS_BUSY); // [RQ12]
	assign is_ldt = is_sys && sys_type == SDC_TYPE_LDT; // [RQ12]

	// class as shown in the status register
	always_comb begin
		if (!desc.loaded) begin
			cls = SDC_CLS_NONE;
		end else if (is_sys) begin
			cls = SDC_CLS_SYSTEM;
		end else if (is_code) begin
			cls = SDC_CLS_CODE;
		end else begin
			cls = SDC_CLS_DATA;
		end
	end

	// ****************************************
	// descriptor fetch sequencer
	// ****************************************
	logic stage_present;
	logic stage_sys;
	logic stage_type_ok;
	sdc_fault_e stage_fault;

	assign stage_present = stage.access[SDC_BIT_PRESENT];
	assign stage_sys = !stage.access[SDC_BIT_CLASS];
	// gates are recognised but never become memory segments here
	assign stage_type_ok = stage.access[3:0] >= SDC_TYPE_TSS_FREE
		&& stage.access[3:0] <= SDC_TYPE_GATE_HI;

	// fault reported at load; a not-present descriptor is still cached
	always_comb begin
		if (!stage_present) begin
			stage_fault = SDC_FLT_NOT_PRESENT; // [RQ3] [RQ14]
		end else if (stage_sys && !stage_type_ok) begin
			stage_fault = SDC_FLT_PROTECT; // [RQ21]
		end else begin
			stage_fault = SDC_FLT_NONE;
		end
	end

	// four 16-bit reads, then an accessed-bit write for code/data descriptors only, all under lock
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state <= SDC_ST_IDLE;
			widx <= 2'h0;
			desc_addr <= 24'h000000;
			stage <= '0;
			desc <= '0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_lock <= 1'b0;
			mem_addr <= 24'h000000;
			mem_wdata <= 16'h0000;
			load_busy <= 1'b0;
			load_done <= 1'b0;
			load_fault <= SDC_FLT_NONE;
		end else begin
			load_done <= 1'b0;
			unique case (state)
				SDC_ST_IDLE: begin
					if (load_valid) begin
						state <= SDC_ST_FETCH;
						widx <= SDC_WORD_LIMIT;
						desc_addr <= load_addr;
						mem_addr <= load_addr;
						mem_req <= 1'b1;
						mem_we <= 1'b0;
						mem_lock <= 1'b1; // [RQ20]
						load_busy <= 1'b1;
					end
				end
				SDC_ST_FETCH: begin
					if (mem_ack) begin
						unique case (widx)
							SDC_WORD_LIMIT: stage.limit <= mem_rdata;
							SDC_WORD_BASE: stage.base[15:0] <= mem_rdata;
							SDC_WORD_ACCESS: begin
								stage.base[23:16] <= mem_rdata[7:0];
								stage.access <= mem_rdata[15:8];
							end
							SDC_WORD_LAST: stage.loaded <= 1'b1; // reserved word ignored [RQ17]
						endcase
						if (widx == SDC_WORD_LAST) begin // eight bytes read [RQ19]
							if (stage.access[SDC_BIT_CLASS]) begin
								// mark accessed in memory, lock still held [RQ4] [RQ20]
								state <= SDC_ST_WBACK;
								stage.access[SDC_BIT_ACCESSED] <= 1'b1;
								mem_we <= 1'b1;
								mem_addr <= desc_addr + {21'h000000, SDC_WORD_ACCESS, 1'b0};
								mem_wdata <= {stage.access | 8'h01, stage.base[23:16]}; // [RQ4]
							end else begin
								state <= SDC_ST_DONE;
								mem_req <= 1'b0;
							end
						end else begin
							widx <= widx + 2'h1;
							mem_addr <= desc_addr + {21'h000000, widx + 2'h1, 1'b0};
						end
					end
				end
				SDC_ST_WBACK: begin
					if (mem_ack) begin
						state <= SDC_ST_DONE;
						mem_req <= 1'b0;
						mem_we <= 1'b0;
					end
				end
				SDC_ST_DONE: begin
					// lock drops only after the last read or write completed
					state <= SDC_ST_IDLE;
					mem_lock <= 1'b0; // [RQ20]
					desc <= stage;
					stage.loaded <= 1'b0;
					load_busy <= 1'b0;
					load_done <= 1'b1;
					load_fault <= stage_fault;
				end
			endcase
		end
	end

	// ****************************************
	// access check against the cached descriptor
	// ****************************************
	sdc_fault_e next_fault;

	// first failing test wins; not-present outranks every other test
	always_comb begin
		next_fault = SDC_FLT_NONE;
		if (!desc.loaded || !present) begin
			next_fault = SDC_FLT_NOT_PRESENT; // [RQ3] [RQ14]
		end else if (is_sys) begin
			if (!(is_tss || is_ldt) || chk.kind == SDC_ACC_EXEC) begin
				next_fault = SDC_FLT_PROTECT; // [RQ21]
			end else if (is_tss && chk.current_privilege > descriptor_privilege) begin
				next_fault = SDC_FLT_PROTECT; // privilege only for task state [RQ15]
			end else if (chk.offset > desc.limit) begin
				next_fault = SDC_FLT_LIMIT; // [RQ13]
			end
		end else if (is_code) begin
			if (chk.kind == SDC_ACC_WRITE) begin
				next_fault = SDC_FLT_PROTECT; // [RQ8]
			end else if (chk.kind == SDC_ACC_READ && !desc.access[SDC_BIT_RW]) begin
				next_fault = SDC_FLT_PROTECT; // execute-only [RQ9]
			end else if (chk.kind == SDC_ACC_EXEC && desc.access[SDC_BIT_DIR]
				&& chk.current_privilege < descriptor_privilege) begin
				next_fault = SDC_FLT_PROTECT; // conforming [RQ10]
			end else if (chk.kind == SDC_ACC_EXEC && !desc.access[SDC_BIT_DIR]
				&& chk.current_privilege != descriptor_privilege) begin
				next_fault = SDC_FLT_PROTECT; // [RQ5]
			end else if (chk.offset > desc.limit) begin
				next_fault = SDC_FLT_LIMIT; // [RQ11]
			end
		end else begin
			if (chk.kind == SDC_ACC_EXEC) begin
				next_fault = SDC_FLT_PROTECT;
			end else if (chk.kind == SDC_ACC_WRITE && !desc.access[SDC_BIT_RW]) begin
				next_fault = SDC_FLT_PROTECT; // read-only [RQ7]
			end else if (chk.current_privilege > descriptor_privilege) begin
				next_fault = SDC_FLT_PROTECT; // [RQ5]
			end else if (desc.access[SDC_BIT_DIR] ? chk.offset <= desc.limit
				: chk.offset > desc.limit) begin
				next_fault = SDC_FLT_LIMIT; // [RQ6]
			end
		end
		// protection off lets every cycle through
		if (!prot_en) begin
			next_fault = SDC_FLT_NONE;
		end
	end

	// one-cycle verdict; allow low means the memory cycle is dropped
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			res <= '0;
		end else begin
			res.done <= chk.valid;
			res.allow <= chk.valid && next_fault == SDC_FLT_NONE; // [RQ18]
			res.fault <= chk.valid ? next_fault : SDC_FLT_NONE; // [RQ18]
		end
	end

	// ****************************************
	// register bus: write side
	// ****************************************
	logic aw_hs;
	logic w_hs;
	logic b_hs;
	logic aw_full;
	logic w_full;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_go;
	logic clr_faults;

	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs = s_axi_wvalid && s_axi_wready;
	assign b_hs = s_axi_bvalid && s_axi_bready;
	assign wr_go = aw_full && w_full && !s_axi_bvalid;
	assign clr_faults = wr_go && wr_addr == SDC_REG_FAULTS;

	// address and data held independently until the response is taken
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
		end else begin
			if (aw_hs) begin
				aw_full <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end else if (b_hs) begin
				aw_full <= 1'b0;
			end
			if (w_hs) begin
				w_full <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end else if (b_hs) begin
				w_full <= 1'b0;
			end
			s_axi_awready <= !(aw_hs || (aw_full && !b_hs));
			s_axi_wready <= !(w_hs || (w_full && !b_hs));
		end
	end

	// commit and answer; unmapped offsets get SLVERR
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= SDC_RESP_OKAY;
			prot_en <= SDC_CTRL_RESET;
		end else begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= SDC_RESP_OKAY;
				unique case (wr_addr)
					SDC_REG_CTRL: begin
						if (wr_strb[0]) begin
							prot_en <= wr_data[0];
						end
					end
					SDC_REG_STATUS, SDC_REG_BASE, SDC_REG_LIMIT, SDC_REG_FAULTS: begin
					end
					default: s_axi_bresp <= SDC_RESP_SLVERR;
				endcase
			end else if (b_hs) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// fault statistics
	// ****************************************
	// a fault in the clearing cycle survives: count restarts at one
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			fault_count <= 16'h0000;
			last_fault <= SDC_FLT_NONE;
		end else begin
			if (res.done && !res.allow) begin
				fault_count <= clr_faults ? 16'h0001 : fault_count + 16'h0001;
				last_fault <= res.fault;
			end else if (clr_faults) begin
				fault_count <= 16'h0000;
			end
		end
	end

	// ****************************************
	// register bus: read side
	// ****************************************
	sdc_status_s status;
	logic ar_hs;
	logic r_hs;

	assign ar_hs = s_axi_arvalid && s_axi_arready;
	assign r_hs = s_axi_rvalid && s_axi_rready;

	always_comb begin
		status = '0;
		status.accessed = desc.access[SDC_BIT_ACCESSED];
		status.busy = load_busy;
		status.loaded = desc.loaded;
		status.descriptor_privilege = descriptor_privilege;
		status.present = present;
		status.type_raw = sys_type;
		status.cls = cls;
		status.last_fault = last_fault;
	end

	// one read at a time; data registered on the address handshake
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= SDC_RESP_OKAY;
		end else begin
			if (ar_hs) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= SDC_RESP_OKAY;
				unique case (s_axi_araddr)
					SDC_REG_CTRL: s_axi_rdata <= {31'h00000000, prot_en};
					SDC_REG_STATUS: s_axi_rdata <= status;
					SDC_REG_BASE: s_axi_rdata <= {8'h00, desc.base}; // [RQ13]
					SDC_REG_LIMIT: s_axi_rdata <= {16'h0000, desc.limit}; // [RQ13]
					SDC_REG_FAULTS: s_axi_rdata <= {16'h0000, fault_count};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= SDC_RESP_SLVERR;
					end
				endcase
			end else if (r_hs) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule

// file: core/sdc_pkg.sv
/*
 * constants, types and carriers for the segment descriptor check block.
 * assumes a 16-bit descriptor memory port and an AXI4-Lite register bus.
 */
//
// Functional notes
// [RQ1] access bit 4 set means code/data descriptor, clear means system or gate
// [RQ2] code/data: bit 3 set is code, clear is data
// [RQ3] present bit 7 clear: base/limit unused, any use faults not-present
// [RQ4] every code/data descriptor access sets accessed bit 0 in memory
// [RQ5] privilege field is access bits 6..5, used in privilege tests
// [RQ6] data: direction 0 needs offset <= limit, 1 needs offset > limit
// [RQ7] data: writable bit 1 clear blocks writes, set permits them
// [RQ8] code segments are never writable
// [RQ9] code: readable bit 1 clear makes segment execute-only
// [RQ10] conforming code runs only when current privilege >= descriptor privilege
// [RQ11] code limit is last valid byte; beyond it is a violation
// [RQ12] system types: 1 free task state, 2 local table, 3 busy task state
// [RQ13] system descriptor yields 24-bit base, 16-bit limit of last byte
// [RQ14] system descriptor with present clear is invalid
// [RQ15] privilege field applies to task state only, ignored for local table
// [RQ16] system control descriptor only when access bit 4 is 0
// [RQ17] software writes zero into reserved descriptor bits
// [RQ18] violating use suppresses memory cycle and raises a fault
// [RQ19] descriptors are fetched as eight bytes from the table
// [RQ20] descriptor reads and updates run as locked bus operations
// [RQ21] undefined system type value raises a protection fault

package sdc_pkg;

	// ****************************************
	// access byte layout
	// ****************************************
	localparam int SDC_BIT_PRESENT = 7;
	localparam int SDC_BIT_DPL_HI = 6;
	localparam int SDC_BIT_DPL_LO = 5;
	localparam int SDC_BIT_CLASS = 4;
	localparam int SDC_BIT_EXEC = 3;
	localparam int SDC_BIT_DIR = 2;
	localparam int SDC_BIT_RW = 1;
	localparam int SDC_BIT_ACCESSED = 0;

	localparam logic [3:0] SDC_TYPE_TSS_FREE = 4'h1;
	localparam logic [3:0] SDC_TYPE_LDT = 4'h2;
	localparam logic [3:0] SDC_TYPE_TSS_BUSY = 4'h3;
	localparam logic [3:0] SDC_TYPE_GATE_LO = 4'h4;
	localparam logic [3:0] SDC_TYPE_GATE_HI = 4'h7;

	// ****************************************
	// descriptor fetch geometry
	// ****************************************
	localparam logic [1:0] SDC_WORD_LIMIT = 2'h0;
	localparam logic [1:0] SDC_WORD_BASE = 2'h1;
	localparam logic [1:0] SDC_WORD_ACCESS = 2'h2;
	localparam logic [1:0] SDC_WORD_LAST = 2'h3;

	// ****************************************
	// register map and bus answers
	// ****************************************
	localparam logic [7:0] SDC_REG_CTRL = 8'h00;
	localparam logic [7:0] SDC_REG_STATUS = 8'h04;
	localparam logic [7:0] SDC_REG_BASE = 8'h08;
	localparam logic [7:0] SDC_REG_LIMIT = 8'h0c;
	localparam logic [7:0] SDC_REG_FAULTS = 8'h10;
	localparam logic SDC_CTRL_RESET = 1'b1;
	localparam logic [1:0] SDC_RESP_OKAY = 2'b00;
	localparam logic [1:0] SDC_RESP_SLVERR = 2'b10;

	// ****************************************
	// enumerations
	// ****************************************
	typedef enum logic [1:0] {
		SDC_ACC_READ = 2'b00,
		SDC_ACC_WRITE = 2'b01,
		SDC_ACC_EXEC = 2'b10
	} sdc_acc_e;

	typedef enum logic [1:0] {
		SDC_FLT_NONE = 2'b00,
		SDC_FLT_NOT_PRESENT = 2'b01,
		SDC_FLT_PROTECT = 2'b10,
		SDC_FLT_LIMIT = 2'b11
	} sdc_fault_e;

	typedef enum logic [1:0] {
		SDC_CLS_NONE = 2'b00,
		SDC_CLS_CODE = 2'b01,
		SDC_CLS_DATA = 2'b10,
		SDC_CLS_SYSTEM = 2'b11
	} sdc_class_e;

	typedef enum logic [1:0] {
		SDC_ST_IDLE = 2'b00,
		SDC_ST_FETCH = 2'b01,
		SDC_ST_WBACK = 2'b10,
		SDC_ST_DONE = 2'b11
	} sdc_state_e;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic loaded;
		logic [7:0] access;
		logic [23:0] base;
		logic [15:0] limit;
	} sdc_desc_s;

	typedef struct packed {
		logic valid;
		sdc_acc_e kind;
		logic [1:0] current_privilege;
		logic [15:0] offset;
	} sdc_chk_s;

	typedef struct packed {
		logic done;
		logic allow;
		sdc_fault_e fault;
	} sdc_res_s;

	typedef struct packed {
		logic [17:0] zero;
		logic accessed;
		logic busy;
		logic loaded;
		logic [1:0] descriptor_privilege;
		logic present;
		logic [3:0] type_raw;
		sdc_class_e cls;
		sdc_fault_e last_fault;
	} sdc_status_s;

endpackage

// file: testbench/sdc_check_asserts.sv
/*
 * port checks on sdc_check, attached by bind.
 * assumes 8-byte aligned descriptors and CTRL address and data offered together.
 */
`timescale 1ns/1ns

module sdc_check_asserts
	import sdc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic load_busy,
	input wire logic load_done,
	input wire sdc_fault_e load_fault,
	input wire sdc_chk_s chk,
	input wire sdc_res_s res,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic mem_lock,
	input wire logic [23:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// ****************************************
	// shadow of the cached descriptor
	// ****************************************
	logic prot;
	logic loaded;
	logic [7:0] acc_n;
	logic [7:0] acc;
	logic [15:0] lim_n;
	logic [15:0] lim;
	logic q;

	// protect enable as software last wrote it
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			prot <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
				s_axi_awaddr == SDC_REG_CTRL && s_axi_wstrb[0]) begin
			prot <= s_axi_wdata[0];
		end
	end

	// words as fetched; the cache only follows at load_done, like the block
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			acc_n <= 8'h00;
			lim_n <= 16'h0000;
		end else if (mem_ack && !mem_we) begin
			if (mem_addr[2:1] == SDC_WORD_ACCESS) acc_n <= mem_rdata[15:8];
			if (mem_addr[2:1] == SDC_WORD_LIMIT) lim_n <= mem_rdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			loaded <= 1'b0;
			acc <= 8'h00;
			lim <= 16'h0000;
		end else if (load_done) begin
			loaded <= 1'b1;
			acc <= acc_n;
			lim <= lim_n;
		end
	end

	// present, loaded and checked
	assign q = chk.valid && prot && loaded && acc[7];

	// ****************************************
	// properties
	// ****************************************
	property p_lock; mem_req |-> mem_lock; endproperty
	a_lock: assert property (p_lock) else $error("memory request without lock");
	property p_start; $rose(load_busy) |-> mem_req && mem_lock; endproperty
	a_start: assert property (p_start) else $error("load began without locked fetch");
	property p_wback; mem_req && mem_we |-> mem_wdata[8] && mem_addr[2:1] == SDC_WORD_ACCESS;
	endproperty
	a_wback: assert property (p_wback) else $error("writeback lacks accessed bit");
	property p_done; chk.valid |=> res.done; endproperty
	a_done: assert property (p_done) else $error("check not answered next cycle");
	property p_ans; res.done |-> $past(chk.valid) && (res.allow == (res.fault == SDC_FLT_NONE));
	endproperty
	a_ans: assert property (p_ans) else $error("answer inconsistent or unasked");
	property p_np; chk.valid && prot && loaded && !acc[7] |=>
		!res.allow && res.fault == SDC_FLT_NOT_PRESENT; endproperty
	a_np: assert property (p_np) else $error("absent segment not faulted");
	property p_code_wr; q && acc[4:3] == 2'b11 && chk.kind == SDC_ACC_WRITE |=>
		res.fault == SDC_FLT_PROTECT; endproperty
	a_code_wr: assert property (p_code_wr) else $error("code segment written");
	property p_data_ro; q && acc[4:3] == 2'b10 && !acc[1] && chk.kind == SDC_ACC_WRITE |=>
		res.fault == SDC_FLT_PROTECT; endproperty
	a_data_ro: assert property (p_data_ro) else $error("read-only data written");
	property p_up_lim; q && acc[4:2] == 3'b100 && chk.kind == SDC_ACC_READ &&
		chk.current_privilege <= acc[6:5] && chk.offset > lim |=> res.fault == SDC_FLT_LIMIT; endproperty
	a_up_lim: assert property (p_up_lim) else $error("expand-up limit missed");
	property p_sys_bad; load_done && acc_n[7:4] == 4'h8 && (acc_n[3:0] == 4'h0 || acc_n[3])
		|-> load_fault == SDC_FLT_PROTECT; endproperty
	a_sys_bad: assert property (p_sys_bad) else $error("undefined system type accepted");
endmodule

bind sdc_check sdc_check_asserts sdc_check_asserts_i (.*);

// file: testbench/sdc_mem.sv
/*
 * one descriptor as four 16-bit words.
 * assumes words are filled only while no load runs; slow adds waits.
 */
`timescale 1ns/1ns

module sdc_mem (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic slow,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [23:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic mem_ack,
	output logic [15:0] mem_rdata
);
	logic [15:0] word [0:3];
	logic [1:0] cnt;

	// one-cycle ack; read data churns outside the ack so stale values never match
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mem_ack <= 1'b0;
			cnt <= 2'h0;
			mem_rdata <= 16'h0000;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack) begin
				if (cnt == (slow ? 2'h2 : 2'h0)) begin
					mem_ack <= 1'b1;
					cnt <= 2'h0;
					mem_rdata <= word[mem_addr[2:1]];
					if (mem_we) word[mem_addr[2:1]] <= mem_wdata;
				end else begin
					cnt <= cnt + 2'h1;
				end
			end
		end
	end
endmodule

// file: testbench/segment_descriptor_check_test.sv
/*
 * self-checking bench for sdc_check.
 * assumes the bound checker is compiled alongside.
 */
`timescale 1ns/1ns

module segment_descriptor_check_test;
	import sdc_pkg::*;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic slow = 1'b0;
	logic load_valid = 1'b0;
	logic [23:0] load_addr = 24'h000000;
	sdc_chk_s chk = '0;
	logic load_busy, load_done, mem_req, mem_we, mem_lock, mem_ack;
	sdc_fault_e load_fault;
	sdc_res_s res;
	logic [23:0] mem_addr;
	logic [15:0] mem_wdata, mem_rdata;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rd;
	logic [1:0] rsp;
	int failures = 0;
	int n_tests = 0;

	always #50 clk_sys = ~clk_sys;

	sdc_check sdc_check_i (.clk_sys(clk_sys), .rstn(rstn), .load_valid(load_valid),
		.load_addr(load_addr), .load_busy(load_busy), .load_done(load_done),
		.load_fault(load_fault), .chk(chk), .res(res), .mem_req(mem_req), .mem_we(mem_we),
		.mem_lock(mem_lock), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	sdc_mem sdc_mem_i (.clk_sys(clk_sys), .rstn(rstn), .slow(slow), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			failures++;
		end
	endtask

	// aw and w offered together, each dropped when taken; ready stays high
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		rsp = bresp;
	endtask

	task automatic rdreg(input logic [7:0] a);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata; rsp = rresp;
	endtask

	// descriptor built by software: reserved word left zero
	task automatic ld(input logic [7:0] a, input logic [15:0] lim, input sdc_fault_e ef);
		sdc_mem_i.word[0] = lim;
		sdc_mem_i.word[1] = 16'h3456;
		sdc_mem_i.word[2] = {a, 8'h12};
		sdc_mem_i.word[3] = 16'h0000;
		load_addr <= 24'h000100;
		load_valid <= 1'b1;
		@(posedge clk_sys);
		load_valid <= 1'b0;
		@(posedge clk_sys iff load_done);
		cmp(load_fault, ef);
		cmp(sdc_mem_i.word[2], {a[7:1], a[0] | a[4], 8'h12});
	endtask

	task automatic ck(input sdc_acc_e k, input logic [1:0] c, input logic [15:0] o,
			input logic ea, input sdc_fault_e ef);
		chk <= '{1'b1, k, c, o};
		@(posedge clk_sys);
		chk <= '0;
		@(posedge clk_sys);
		cmp(res, {1'b1, ea, ef});
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_code;
		slow <= 1'b1;
		ld(8'h9a, 16'h0100, SDC_FLT_NONE);
		ck(SDC_ACC_EXEC, 2'h0, 16'h0100, 1'b1, SDC_FLT_NONE);
		ck(SDC_ACC_WRITE, 2'h0, 16'h0000, 1'b0, SDC_FLT_PROTECT);
		ck(SDC_ACC_READ, 2'h0, 16'h0101, 1'b0, SDC_FLT_LIMIT);
		slow <= 1'b0;
		ld(8'h98, 16'h0100, SDC_FLT_NONE);
		ck(SDC_ACC_READ, 2'h0, 16'h0000, 1'b0, SDC_FLT_PROTECT);
		ld(8'hde, 16'hffff, SDC_FLT_NONE);
		ck(SDC_ACC_EXEC, 2'h1, 16'h0000, 1'b0, SDC_FLT_PROTECT);
		ck(SDC_ACC_EXEC, 2'h3, 16'hffff, 1'b1, SDC_FLT_NONE);
		ck(SDC_ACC_READ, 2'h3, 16'h0000, 1'b1, SDC_FLT_NONE);
		$display("t_code done");
	endtask

	task automatic t_data;
		ld(8'h92, 16'h0200, SDC_FLT_NONE);
		ck(SDC_ACC_WRITE, 2'h0, 16'h0200, 1'b1, SDC_FLT_NONE);
		ck(SDC_ACC_READ, 2'h0, 16'h0201, 1'b0, SDC_FLT_LIMIT);
		ck(SDC_ACC_EXEC, 2'h0, 16'h0000, 1'b0, SDC_FLT_PROTECT);
		ld(8'h90, 16'h0200, SDC_FLT_NONE);
		ck(SDC_ACC_WRITE, 2'h0, 16'h0000, 1'b0, SDC_FLT_PROTECT);
		ld(8'hb6, 16'h0200, SDC_FLT_NONE);
		ck(SDC_ACC_READ, 2'h1, 16'h0200, 1'b0, SDC_FLT_LIMIT);
		ck(SDC_ACC_WRITE, 2'h1, 16'h0201, 1'b1, SDC_FLT_NONE);
		ck(SDC_ACC_READ, 2'h2, 16'h0201, 1'b0, SDC_FLT_PROTECT);
		$display("t_data done");
	endtask

	task automatic t_absent;
		ld(8'h12, 16'h0200, SDC_FLT_NOT_PRESENT);
		ck(SDC_ACC_READ, 2'h0, 16'h0000, 1'b0, SDC_FLT_NOT_PRESENT);
		ld(8'h02, 16'h0200, SDC_FLT_NOT_PRESENT);
		$display("t_absent done");
	endtask

	task automatic t_sys;
		int t;
		for (t = 1; t <= 3; t++) begin
			ld({4'h8, 4'(t)}, 16'h0abc, SDC_FLT_NONE);
			rdreg(SDC_REG_STATUS);
			cmp(rd & 32'h0ffc, 32'h090c | (t << 4));
			rdreg(SDC_REG_BASE);
			cmp(rd, 32'h00123456);
			rdreg(SDC_REG_LIMIT);
			cmp(rd, 32'h00000abc);
		end
		ld(8'ha1, 16'h0abc, SDC_FLT_NONE);
		ck(SDC_ACC_READ, 2'h2, 16'h0000, 1'b0, SDC_FLT_PROTECT);
		ld(8'ha2, 16'h0abc, SDC_FLT_NONE);
		ck(SDC_ACC_READ, 2'h3, 16'h0abc, 1'b1, SDC_FLT_NONE);
		ld(8'h88, 16'h0abc, SDC_FLT_PROTECT);
		ld(8'h80, 16'h0abc, SDC_FLT_PROTECT);
		$display("t_sys done");
	endtask

	// reset values, unmapped offsets, protect switch, fault count
	task automatic t_regs;
		rdreg(SDC_REG_CTRL);
		cmp({rsp, rd[29:0]}, {SDC_RESP_OKAY, 30'h1});
		rdreg(8'h20);
		cmp({rsp, rd[29:0]}, {SDC_RESP_SLVERR, 30'h0});
		wr(8'h24, 32'h0);
		cmp(rsp, SDC_RESP_SLVERR);
		wr(SDC_REG_FAULTS, 32'h0);
		ld(8'h9a, 16'h0010, SDC_FLT_NONE);
		ck(SDC_ACC_WRITE, 2'h0, 16'h0000, 1'b0, SDC_FLT_PROTECT);
		rdreg(SDC_REG_FAULTS);
		cmp(rd, 32'h1);
		wr(SDC_REG_CTRL, 32'h0);
		ck(SDC_ACC_WRITE, 2'h0, 16'h0000, 1'b1, SDC_FLT_NONE);
		wr(SDC_REG_CTRL, 32'h1);
		wr(SDC_REG_FAULTS, 32'h0);
		rdreg(SDC_REG_FAULTS);
		cmp(rd, 32'h0);
		$display("t_regs done");
	endtask

	// ****************************************
	// run control
	// ****************************************
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// well above the few hundred cycles needed
	initial begin
		#(100 * 20000);
		failures++;
		tally_and_finish();
	end

	initial begin
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		t_regs();
		t_code();
		t_data();
		t_absent();
		t_sys();
		tally_and_finish();
	end
endmodule
